// *** hw/ecph_pkg.sv ***
// Shared constants and types for the parallel port peripheral handshake
package ecph_pkg;

    // Delays are in system clock periods; clk_i is the system clock
    localparam int SCLK_PER_CLK = 1;
    localparam int BUSY_ASSERT_SCLK = 8;
    localparam int BUSY_RELEASE_SCLK = 8;
    localparam int GRANT_DROP_SCLK = 5;
    localparam int ACK_SCLK = 3;
    // Synchroniser eats most of the end window, so only one clock is left
    localparam int END_SCLK = 1;
    localparam int GIVE_SCLK = 1;
    localparam int BUSY_ASSERT_CYC = BUSY_ASSERT_SCLK * SCLK_PER_CLK;
    localparam int BUSY_RELEASE_CYC = BUSY_RELEASE_SCLK * SCLK_PER_CLK;
    localparam int GRANT_DROP_CYC = GRANT_DROP_SCLK * SCLK_PER_CLK;
    localparam int ACK_CYC = ACK_SCLK * SCLK_PER_CLK;
    localparam int END_CYC = END_SCLK * SCLK_PER_CLK;
    localparam int GIVE_CYC = GIVE_SCLK * SCLK_PER_CLK;

    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Pins as seen from the host cable, all asynchronous to clk_i
    typedef struct packed {
        logic strobe_n;
        logic autofeed_n;
        logic dir_request_n;
        logic [7:0] data;
    } ecph_pins_t;

    localparam ecph_pins_t PINS_IDLE = '{strobe_n: 1'b1, autofeed_n: 1'b1, dir_request_n: 1'b1, data: 8'h00};

    // Forward byte handed to the user side
    typedef struct packed {
        logic is_addr;
        logic [7:0] data;
    } ecph_fwd_t;

    localparam ecph_fwd_t FWD_ZERO = '{is_addr: 1'b0, data: 8'h00};

    typedef enum logic [11:0] {
        ST_IDLE   = 12'h001,
        ST_F_ACK  = 12'h002,
        ST_F_HOLD = 12'h004,
        ST_F_REL  = 12'h008,
        ST_R_GRNT = 12'h010,
        ST_R_FTCH = 12'h020,
        ST_R_ACK  = 12'h040,
        ST_R_HOST = 12'h080,
        ST_R_UACK = 12'h100,
        ST_R_NEXT = 12'h200,
        ST_R_END  = 12'h400,
        ST_R_GIVE = 12'h800
    } ecph_state_t;

endpackage

// *** hw/ecph_sync.sv ***
// Two-stage synchroniser for the host cable inputs
`timescale 1ns/1ps
module ecph_sync
    import ecph_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Pins in, synchronised out
    input wire ecph_pins_t pins_i,
    output ecph_pins_t pins_o
);

    ecph_pins_t meta_reg;
    ecph_pins_t meta_next;
    ecph_pins_t sync_reg;
    ecph_pins_t sync_next;

    // First stage feeds only the second stage
    always_comb begin
        meta_next = pins_i;
        sync_next = meta_reg;
        if (!rst_n_i) begin
            meta_next = PINS_IDLE;
            sync_next = PINS_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
    end

    assign pins_o = sync_reg;

endmodule

// *** hw/ecph_top.sv ***
// Peripheral side extended-capability parallel port handshake
`timescale 1ns/1ps
module ecph_top
    import ecph_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Host cable inputs
    input wire logic host_strobe_low_i,
    input wire logic autofeed_command_flag_n_i,
    input wire logic dir_request_n_i,
    input wire logic [7:0] host_data_lines_i,
    // Host cable outputs
    output logic [7:0] host_data_lines_o,
    output logic host_data_oe_o,
    output logic busy_line_o,
    output logic reverse_grant_line_o,
    output logic ack_n_o,
    output logic fault_n_o,
    // Forward bytes to the user
    output ecph_fwd_t fwd_o,
    output logic fwd_valid_o,
    // Reverse bytes from the user
    input wire logic [7:0] rev_data_i,
    input wire logic rev_valid_i,
    output logic rev_ready_o
);

    function automatic logic dly_done(input logic [CNT_W-1:0] cnt, input int cyc);
        dly_done = cnt >= CNT_W'(cyc - 1);
    endfunction

    ecph_pins_t pins_raw;
    ecph_pins_t pins_s;
    logic strobe_prev_reg;
    logic strobe_prev_next;
    logic str_fall;
    logic str_rise;
    logic rev_ph;

    assign pins_raw = '{strobe_n: host_strobe_low_i, autofeed_n: autofeed_command_flag_n_i,
                        dir_request_n: dir_request_n_i, data: host_data_lines_i};

    ecph_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pins_i(pins_raw),
        .pins_o(pins_s)
    );

    assign str_fall = strobe_prev_reg && !pins_s.strobe_n;
    assign str_rise = !strobe_prev_reg && pins_s.strobe_n;

    ecph_state_t state_reg;
    ecph_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic cmd_reg;
    logic cmd_next;
    logic [7:0] dout_reg;
    logic [7:0] dout_next;
    logic oe_reg;
    logic oe_next;
    logic busy_reg;
    logic busy_next;
    logic grant_reg;
    logic grant_next;
    logic ack_n_reg;
    logic ack_n_next;
    logic fault_n_reg;
    logic fault_n_next;
    ecph_fwd_t fwd_reg;
    ecph_fwd_t fwd_next;
    logic fwd_valid_reg;
    logic fwd_valid_next;
    logic rev_ready_reg;
    logic rev_ready_next;

    // Reverse phase that the host may abort by releasing its request
    assign rev_ph = state_reg inside {ST_R_GRNT, ST_R_FTCH, ST_R_ACK, ST_R_HOST, ST_R_UACK, ST_R_NEXT};

    always_comb begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        dout_next = dout_reg;
        oe_next = oe_reg;
        busy_next = busy_reg;
        grant_next = grant_reg;
        ack_n_next = ack_n_reg;
        fault_n_next = 1'b1;
        fwd_next = fwd_reg;
        fwd_valid_next = 1'b0;
        rev_ready_next = 1'b0;
        strobe_prev_next = pins_s.strobe_n;
        case (state_reg)
            ST_IDLE: begin
                if (!pins_s.dir_request_n) begin
                    state_next = ST_R_GRNT;
                end else if (str_fall) begin
                    // Autofeed is valid once strobe is seen low
                    cmd_next = !pins_s.autofeed_n;
                    state_next = ST_F_ACK;
                end
            end
            ST_F_ACK: begin
                if (dly_done(cnt_reg, BUSY_ASSERT_CYC)) begin
                    busy_next = 1'b1;
                    state_next = ST_F_HOLD;
                end
            end
            ST_F_HOLD: begin
                if (str_rise) begin
                    // Command bytes are always channel addresses, no run-length counts
                    fwd_next = '{is_addr: cmd_reg, data: pins_s.data};
                    fwd_valid_next = 1'b1;
                    state_next = ST_F_REL;
                end
            end
            ST_F_REL: begin
                if (dly_done(cnt_reg, BUSY_RELEASE_CYC)) begin
                    busy_next = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            ST_R_GRNT: begin
                if (dly_done(cnt_reg, GRANT_DROP_CYC)) begin
                    grant_next = 1'b0;
                    oe_next = 1'b1;
                    state_next = ST_R_FTCH;
                end
            end
            ST_R_FTCH: begin
                if (rev_valid_i) begin
                    dout_next = rev_data_i;
                    busy_next = 1'b1;
                    rev_ready_next = 1'b1;
                    state_next = ST_R_ACK;
                end
            end
            ST_R_ACK: begin
                if (dly_done(cnt_reg, ACK_CYC)) begin
                    ack_n_next = 1'b0;
                    state_next = ST_R_HOST;
                end
            end
            ST_R_HOST: begin
                if (pins_s.autofeed_n) begin
                    state_next = ST_R_UACK;
                end
            end
            ST_R_UACK: begin
                if (dly_done(cnt_reg, ACK_CYC)) begin
                    ack_n_next = 1'b1;
                    state_next = ST_R_NEXT;
                end
            end
            ST_R_NEXT: begin
                if (!pins_s.autofeed_n) begin
                    state_next = ST_R_FTCH;
                end
            end
            ST_R_END: begin
                if (dly_done(cnt_reg, END_CYC)) begin
                    oe_next = 1'b0;
                    busy_next = 1'b0;
                    ack_n_next = 1'b1;
                    state_next = ST_R_GIVE;
                end
            end
            ST_R_GIVE: begin
                if (dly_done(cnt_reg, GIVE_CYC)) begin
                    grant_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Request release overrides every reverse step before ST_R_END
        if (rev_ph && pins_s.dir_request_n) begin
            state_next = ST_R_END;
        end
        // Counter restarts whenever the handshake moves on
        if (state_next != state_reg) begin
            cnt_next = CNT_ZERO;
        end else if (cnt_reg != CNT_MAX) begin
            cnt_next = cnt_reg + 4'h1;
        end else begin
            cnt_next = cnt_reg;
        end
        if (!rst_n_i) begin
            state_next = ST_IDLE;
            cnt_next = CNT_ZERO;
            cmd_next = 1'b0;
            dout_next = BYTE_ZERO;
            oe_next = 1'b0;
            busy_next = 1'b0;
            grant_next = 1'b1;
            ack_n_next = 1'b1;
            fault_n_next = 1'b1;
            fwd_next = FWD_ZERO;
            fwd_valid_next = 1'b0;
            rev_ready_next = 1'b0;
            strobe_prev_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
        cmd_reg <= cmd_next;
        dout_reg <= dout_next;
        oe_reg <= oe_next;
        busy_reg <= busy_next;
        grant_reg <= grant_next;
        ack_n_reg <= ack_n_next;
        fault_n_reg <= fault_n_next;
        fwd_reg <= fwd_next;
        fwd_valid_reg <= fwd_valid_next;
        rev_ready_reg <= rev_ready_next;
        strobe_prev_reg <= strobe_prev_next;
    end

    assign host_data_lines_o = dout_reg;
    assign host_data_oe_o = oe_reg;
    assign busy_line_o = busy_reg;
    assign reverse_grant_line_o = grant_reg;
    assign ack_n_o = ack_n_reg;
    assign fault_n_o = fault_n_reg;
    assign fwd_o = fwd_reg;
    assign fwd_valid_o = fwd_valid_reg;
    assign rev_ready_o = rev_ready_reg;

    property p_busy_assert;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(state_reg == ST_F_ACK) |-> !busy_line_o [*8] ##1 busy_line_o;
    endproperty
    a_busy_assert: assert property (p_busy_assert) else $error("Busy rise delay wrong");

    property p_capture;
        @(posedge clk_i) disable iff (!rst_n_i)
        fwd_valid_o |-> $past(str_rise) && fwd_o.data == $past(pins_s.data) && busy_line_o;
    endproperty
    a_capture: assert property (p_capture) else $error("Forward byte not taken at strobe rise");

    property p_busy_release;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(state_reg == ST_F_REL) |-> busy_line_o [*8] ##1 !busy_line_o;
    endproperty
    a_busy_release: assert property (p_busy_release) else $error("Busy release delay wrong");

    property p_cmd_flag;
        @(posedge clk_i) disable iff (!rst_n_i)
        fwd_valid_o |-> fwd_o.is_addr == cmd_reg;
    endproperty
    a_cmd_flag: assert property (p_cmd_flag) else $error("Command byte not flagged as address");

    property p_fault_idle;
        @(posedge clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> fault_n_o;
    endproperty
    a_fault_idle: assert property (p_fault_idle) else $error("Fault line driven active");

    property p_rev_busy;
        @(posedge clk_i) disable iff (!rst_n_i)
        state_reg inside {ST_R_ACK, ST_R_HOST, ST_R_UACK, ST_R_NEXT} |-> busy_line_o;
    endproperty
    a_rev_busy: assert property (p_rev_busy) else $error("Busy low during reverse transfer");

    property p_grant_drop;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(state_reg == ST_R_GRNT) |-> reverse_grant_line_o [*5] ##1 !reverse_grant_line_o;
    endproperty
    a_grant_drop: assert property (p_grant_drop) else $error("Grant line drop delay wrong");

    property p_drive_on_grant;
        @(posedge clk_i) disable iff (!rst_n_i)
        $fell(reverse_grant_line_o) |-> host_data_oe_o && !busy_line_o;
    endproperty
    a_drive_on_grant: assert property (p_drive_on_grant) else $error("Bus not driven at grant");

    property p_ack;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(state_reg == ST_R_ACK) |-> ack_n_o [*3] ##1 (!ack_n_o && busy_line_o);
    endproperty
    a_ack: assert property (p_ack) else $error("Acknowledge delay wrong");

    property p_end;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(state_reg == ST_R_END) && host_data_oe_o
        |-> host_data_oe_o ##1 (!host_data_oe_o && !busy_line_o && !reverse_grant_line_o)
            ##1 reverse_grant_line_o;
    endproperty
    a_end: assert property (p_end) else $error("Reverse end sequence wrong");

endmodule

// *** dv/ecph_host_model.sv ***
// Host side parallel port model that drives the peripheral cable
`timescale 1ns/1ps
module ecph_host_model (
    // Clock
    input wire logic clk_i,
    // Lines from the peripheral; fault is left unconnected on purpose
    input wire logic busy_line_i,
    input wire logic reverse_grant_line_i,
    input wire logic ack_n_i,
    input wire logic [7:0] bus_i,
    // Lines to the peripheral
    output logic strobe_n_o,
    output logic autofeed_n_o,
    output logic dir_request_n_o,
    output logic [7:0] drv_data_o,
    output logic drv_en_o
);
    initial begin
        strobe_n_o = 1'b1;
        autofeed_n_o = 1'b1;
        dir_request_n_o = 1'b1;
        drv_data_o = 8'h00;
        drv_en_o = 1'b1;
    end

    function automatic logic pick(input int sel);
        case (sel)
            0: return busy_line_i;
            1: return reverse_grant_line_i;
            default: return ack_n_i;
        endcase
    endfunction

    // Bounded wait; n counts rising edges since the call, up to 400
    task automatic wait_lvl(input int sel, input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (pick(sel) !== lvl && n < 400);
    endtask

    task automatic fwd_byte(input logic cmd, input logic [7:0] b, output int t_ack, output int t_rel);
        @(negedge clk_i);
        drv_en_o = 1'b1;
        drv_data_o = b;
        autofeed_n_o = ~cmd;
        strobe_n_o = 1'b0;
        wait_lvl(0, 1'b1, t_ack);
        // Strobe stays low a clock and a half past busy
        repeat (2) @(negedge clk_i);
        strobe_n_o = 1'b1;
        wait_lvl(0, 1'b0, t_rel);
        // Half a clock of gap before the task returns
        @(negedge clk_i);
    endtask

    task automatic rev_open(output int t_grant);
        @(negedge clk_i);
        drv_en_o = 1'b0;
        autofeed_n_o = 1'b0;
        @(negedge clk_i);
        dir_request_n_o = 1'b0;
        wait_lvl(1, 1'b0, t_grant);
    endtask

    task automatic rev_byte(output logic [7:0] got);
        int n;
        wait_lvl(2, 1'b0, n);
        got = bus_i;
        @(negedge clk_i);
        autofeed_n_o = 1'b1;
        wait_lvl(2, 1'b1, n);
        @(negedge clk_i);
        autofeed_n_o = 1'b0;
    endtask

    task automatic rev_close(output int t_grant);
        @(negedge clk_i);
        dir_request_n_o = 1'b1;
        wait_lvl(1, 1'b1, t_grant);
        // Host takes the bus back only after the grant returns
        @(negedge clk_i);
        autofeed_n_o = 1'b1;
        drv_en_o = 1'b1;
    endtask
endmodule

// *** dv/ecp_peripheral_handshake_tb.sv ***
// Self-checking bench for the parallel port peripheral handshake
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((ex) !== (gt)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module ecp_peripheral_handshake_tb
    import ecph_pkg::*;
;
    logic clk, rst_n, strobe_n, autofeed_n, dir_req_n, h_en, rev_valid;
    logic [7:0] h_data, rev_data, dev_data, pin_data;
    logic [7:0] float_pat = 8'h5a;
    logic oe, busy, grant, ack_n, fault_n, fwd_valid, rev_ready;
    ecph_fwd_t fwd;
    ecph_fwd_t fwd_q[$];
    ecph_fwd_t fwd_exp;
    logic [7:0] rev_q[$];
    int err_total = 0;
    int tests_run = 0;
    int seed = 32'h413e;
    int cyc = 0;
    int ack_cnt = -1;

    // Released bus is not held: show a changing pattern
    always @(posedge clk) float_pat <= ~float_pat;
    assign pin_data = oe ? dev_data : (h_en ? h_data : float_pat);

    ecph_top DUT (.clk_i(clk), .rst_n_i(rst_n), .host_strobe_low_i(strobe_n),
        .autofeed_command_flag_n_i(autofeed_n), .dir_request_n_i(dir_req_n), .host_data_lines_i(pin_data),
        .host_data_lines_o(dev_data), .host_data_oe_o(oe), .busy_line_o(busy), .reverse_grant_line_o(grant),
        .ack_n_o(ack_n), .fault_n_o(fault_n), .fwd_o(fwd), .fwd_valid_o(fwd_valid), .rev_data_i(rev_data),
        .rev_valid_i(rev_valid), .rev_ready_o(rev_ready));

    ecph_host_model HOST (.clk_i(clk), .busy_line_i(busy), .reverse_grant_line_i(grant), .ack_n_i(ack_n),
        .bus_i(pin_data), .strobe_n_o(strobe_n), .autofeed_n_o(autofeed_n), .dir_request_n_o(dir_req_n),
        .drv_data_o(h_data), .drv_en_o(h_en));

    task automatic summarize();
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            summarize();
        end
    end

    // Forward model and reverse acknowledge monitor
    always @(posedge clk) begin
        #1;
        if (rst_n === 1'b1) `CHK("fault line", 1'b1, fault_n)
        if (fwd_valid === 1'b1) begin
            // An unexpected pulse matches only an address byte of 8'hff
            fwd_exp = '1;
            if (fwd_q.size() > 0) fwd_exp = fwd_q.pop_front();
            `CHK("forward byte", fwd_exp, fwd)
        end
        if (rev_ready === 1'b1) begin
            ack_cnt = 0;
        end else if (ack_cnt >= 0) begin
            ack_cnt++;
            if (ack_n === 1'b0) begin
                `CHK("ack delay", 1'b1, ack_cnt inside {[3:4]})
                `CHK("busy in reverse", 1'b1, busy)
                ack_cnt = -1;
            end
        end
    end

    task automatic feed(input int n);
        logic [7:0] b;
        int k;
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            @(negedge clk);
            repeat (b[1:0]) @(negedge clk);
            rev_data = b;
            rev_valid = 1'b1;
            k = 0;
            do begin
                @(posedge clk);
                #1;
                k++;
            end while (rev_ready !== 1'b1 && k < 400);
            rev_q.push_back(b);
            @(negedge clk);
            rev_valid = 1'b0;
            rev_data = 8'($random(seed));
        end
    endtask

    task automatic forward(input int n);
        logic cmd;
        logic [7:0] b;
        int ta, tr;
        for (int i = 0; i < n; i++) begin
            cmd = i[0] ^ i[2];
            b = (i == 0) ? 8'h80 : 8'($random(seed));
            fwd_q.push_back('{is_addr: cmd, data: b});
            HOST.fwd_byte(cmd, b, ta, tr);
            `CHK("busy rise delay", 1'b1, ta > 8 && ta < 400)
            `CHK("busy fall delay", 1'b1, tr > 8 && tr < 400)
        end
        `CHK("forward bytes left", 0, fwd_q.size())
    endtask

    initial begin
        logic [7:0] got;
        logic [7:0] exp_b;
        int tg;
        rst_n = 1'b0;
        rev_valid = 1'b0;
        rev_data = 8'h00;
        repeat (3) @(negedge clk);
        `CHK("grant in reset", 1'b1, grant)
        `CHK("busy in reset", 1'b0, busy)
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        forward(8);
        HOST.rev_open(tg);
        `CHK("grant delay", 1'b1, tg inside {[6:8]})
        `CHK("bus driven on grant", 1'b1, oe)
        fork
            feed(5);
            for (int i = 0; i < 5; i++) begin
                HOST.rev_byte(got);
                exp_b = (rev_q.size() > 0) ? rev_q.pop_front() : ~got;
                `CHK("reverse byte", exp_b, got)
            end
        join
        `CHK("busy before end", 1'b1, busy)
        HOST.rev_close(tg);
        `CHK("end delay", 1'b1, tg inside {[4:7]})
        `CHK("bus released", 1'b0, oe)
        `CHK("busy released", 1'b0, busy)
        `CHK("ack idle", 1'b1, ack_n)
        forward(3);
        summarize();
    end
endmodule
